// ### ssel_eeprom_model.sv
// Far-side model: EEPROM probe and load answers
`default_nettype none

module ssel_eeprom_model
  import ssel_pkg::*;
(
  // Clock, reset, answer set-up {delay, found, large, sig}
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [5:0] i_cfg,
  // Requests from the device
  input  wire logic       i_probe_req,
  input  wire logic       i_load_req,
  // Answers
  output var  logic       o_probe_done,
  output var  logic [2:0] o_probe,
  output var  ssel_pin_drv_t o_drv,
  output var  logic       o_load_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_ff;
  // Delay counter, so answers come prompt or slow
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !(i_probe_req || i_load_req))
      cnt_ff <= 4'h0;
    else
      cnt_ff <= cnt_ff + 4'h1;
  end
  // answer, results scrambled when not valid
  assign o_probe_done = i_probe_req && cnt_ff == {1'b0, i_cfg[5:3]};
  assign o_probe = o_probe_done ? i_cfg[2:0] : ~i_cfg[2:0];
  assign o_drv = ssel_pin_drv_t'(cnt_ff[2:0]);
  assign o_load_done = i_load_req && cnt_ff[3];
endmodule

`default_nettype wire

// ### ssel_params.svh
// Constants for the strap latch and configuration select block
`ifndef SSEL_PARAMS_SVH
`define SSEL_PARAMS_SVH

// Strap defaults, as the internal pulls leave the pins
`define SSEL_FLOW_CTRL_RST  1'b1
`define SSEL_FIBER_RST      1'b0
`define SSEL_ADDR_RST       2'h0

// Chip address code that selects master load from the small or large EEPROM
`define SSEL_ADDR_MASTER    2'h0

// Synchroniser depth for every pin input
`define SSEL_SYNC_STAGES    2

// Strap field positions inside the packed strap word
`define SSEL_POS_FLOW       3
`define SSEL_POS_FIBER      2
`define SSEL_POS_ADDR_HI    1
`define SSEL_POS_ADDR_LO    0

// Serial clock edges allowed while select idles during a write
`define SSEL_IDLE_CLK_CNT   2'h1

`endif

// ### ssel_pkg.sv
// Types shared by the strap latch and configuration select block
`default_nettype none

package ssel_pkg;

  // Latched strap values, held from reset release to next reset
  typedef struct packed {
    logic       flow_ctrl_en;
    logic       port4_fiber;
    logic [1:0] chip_addr;
  } ssel_straps_t;

  // Drive values for the three EEPROM pins during probe and load
  typedef struct packed {
    logic select;
    logic clock;
    logic data;
  } ssel_pin_drv_t;

  // Where the configuration came from
  typedef enum logic [1:0] {
    SSEL_SRC_DEFAULTS = 2'h0,
    SSEL_SRC_SMALL    = 2'h1,
    SSEL_SRC_FIRST_CONFIG_BANK    = 2'h2
  } ssel_src_t;

  // Serial timing that outside register writes must follow
  typedef enum logic {
    SSEL_WR_LARGE = 1'b0,
    SSEL_WR_SMALL = 1'b1
  } ssel_wr_timing_t;

  // Sequencer states, Gray coded along capture-probe-load-run
  typedef enum logic [1:0] {
    SSEL_ST_CAPTURE = 2'b00,
    SSEL_ST_PROBE   = 2'b01,
    SSEL_ST_LOAD    = 2'b11,
    SSEL_ST_RUN     = 2'b10
  } ssel_state_t;

endpackage

`default_nettype wire

// ### ssel_strap_latch.sv
// Strap capture at power-on reset and configuration source select
`include "ssel_params.svh"
`default_nettype none

module ssel_strap_latch
  import ssel_pkg::*;
(
  // Core clock and synchronous reset
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  // Power-on reset pin, active low, asynchronous
  input  wire logic      i_power_on_reset_low,
  // Strap pins, asynchronous
  input  wire logic      i_flow_ctrl_strap,
  input  wire logic      i_port4_fiber_select,
  input  wire logic      i_chip_addr_strap_lo,
  input  wire logic      i_chip_addr_strap_hi,
  // EEPROM probe results from the loader
  input  wire logic      i_probe_done,
  input  wire logic      i_probe_found,
  input  wire logic      i_probe_large,
  input  wire logic      i_probe_sig_ok,
  // Loader pin drive and completion
  input  wire ssel_pin_drv_t i_load_drv,
  input  wire logic      i_load_done,
  // EEPROM select pin, two-way
  input  wire logic      i_eeprom_select_pin,
  output var  logic      o_eeprom_select_pin,
  output var  logic      o_eeprom_select_pin_oe_n,
  // EEPROM serial clock pin, two-way
  input  wire logic      i_eeprom_clock_pin,
  output var  logic      o_eeprom_clock_pin,
  output var  logic      o_eeprom_clock_pin_oe_n,
  // EEPROM data out pin, two-way
  input  wire logic      i_eeprom_data_out_pin,
  output var  logic      o_eeprom_data_out_pin,
  output var  logic      o_eeprom_data_out_pin_oe_n,
  // Latched configuration
  output var  ssel_straps_t    o_straps,
  output var  logic            o_master_mode,
  output var  ssel_src_t       o_cfg_src,
  output var  ssel_wr_timing_t o_wr_timing,
  // Sequencing status
  output var  logic      o_probe_req,
  output var  logic      o_load_req,
  output var  logic      o_cfg_ready,
  // Outside register write link
  output var  logic      o_link_rise,
  output var  logic      o_link_data,
  output var  logic      o_wr_commit,
  output var  logic      o_idle_clk_error
);

  localparam int NSYNC = 8;

  // Synchronised pin levels
  logic [NSYNC-1:0] pin_async;
  logic [NSYNC-1:0] pin_rst_val;
  logic [NSYNC-1:0] pin_sync;

  assign pin_async = {i_power_on_reset_low,
                      i_flow_ctrl_strap,
                      i_port4_fiber_select,
                      i_chip_addr_strap_hi,
                      i_chip_addr_strap_lo,
                      i_eeprom_select_pin,
                      i_eeprom_clock_pin,
                      i_eeprom_data_out_pin};

  // Reset shown as asserted until the chain fills
  assign pin_rst_val = {1'b0, `SSEL_FLOW_CTRL_RST, `SSEL_FIBER_RST,
                        `SSEL_ADDR_RST, 3'h0};

  ssel_sync #(
    .WIDTH     (NSYNC)
  ) u_sync (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_async   (pin_async),
    .i_rst_val (pin_rst_val),
    .o_sync    (pin_sync)
  );

  // Named views of the synchronised pins
  wire logic       por_low_s   = pin_sync[7];
  wire logic       flow_s      = pin_sync[6];
  wire logic       fiber_s     = pin_sync[5];
  wire logic [1:0] addr_s      = pin_sync[4:3];
  wire logic       link_sel_s  = pin_sync[2];
  wire logic       link_clk_s  = pin_sync[1];
  wire logic       link_dat_s  = pin_sync[0];
  wire logic       por_active  = ~por_low_s;

  // Strap word assembly from the sampled pins
  function automatic ssel_straps_t pack_straps(input logic flow,
                                                input logic fiber,
                                                input logic [1:0] addr);
    ssel_straps_t s;
    s.flow_ctrl_en = flow;
    s.port4_fiber  = fiber;
    s.chip_addr    = addr;
    return s;
  endfunction

  // Latched straps
  ssel_straps_t straps_ff;
  ssel_straps_t nxt_straps;
  ssel_straps_t strap_rst;

  assign strap_rst = pack_straps(`SSEL_FLOW_CTRL_RST, `SSEL_FIBER_RST,
                                 `SSEL_ADDR_RST);

  // sample all straps
  // Track pins while reset is held, so the last value wins at release
  // frozen after release
  assign nxt_straps = por_active
                      ? pack_straps(flow_s, fiber_s, addr_s)
                      : straps_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      straps_ff <= strap_rst;
    else
      straps_ff <= nxt_straps;
  end

  wire logic is_master = (straps_ff.chip_addr == `SSEL_ADDR_MASTER);

  // Probe outcome decode
  wire logic probe_small = i_probe_found & ~i_probe_large & i_probe_sig_ok;
  wire logic probe_large = i_probe_found & i_probe_large;

  // Sequencer state and configuration choice
  ssel_state_t     state_ff;
  ssel_state_t     nxt_state;
  ssel_src_t       src_ff;
  ssel_src_t       nxt_src;
  ssel_wr_timing_t timing_ff;
  ssel_wr_timing_t nxt_timing;

  // Next state; reset pin low always returns to capture
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_src    = src_ff;
    nxt_timing = timing_ff;
    if (por_active)
    begin
      nxt_state  = SSEL_ST_CAPTURE;
      nxt_src    = SSEL_SRC_DEFAULTS;
      nxt_timing = SSEL_WR_LARGE;
    end
    else
    begin
      case (state_ff)
        SSEL_ST_CAPTURE:
        begin
          // only master chips read an EEPROM
          nxt_state = is_master ? SSEL_ST_PROBE : SSEL_ST_RUN;
        end
        SSEL_ST_PROBE:
        begin
          if (i_probe_done)
          begin
            if (probe_small)
            begin
              nxt_state  = SSEL_ST_LOAD;
              nxt_src    = SSEL_SRC_SMALL;
              nxt_timing = SSEL_WR_SMALL;
            end
            else if (probe_large)
            begin
              nxt_state  = SSEL_ST_LOAD;
              nxt_src    = SSEL_SRC_FIRST_CONFIG_BANK;
              nxt_timing = SSEL_WR_LARGE;
            end
            else
            begin
              nxt_state  = SSEL_ST_RUN;
              nxt_src    = SSEL_SRC_DEFAULTS;
              nxt_timing = SSEL_WR_LARGE;
            end
          end
        end
        SSEL_ST_LOAD:
        begin
          if (i_load_done)
            nxt_state = SSEL_ST_RUN;
        end
        SSEL_ST_RUN:
        begin
          nxt_state = SSEL_ST_RUN;
        end
        default:
        begin
          nxt_state = SSEL_ST_CAPTURE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff  <= SSEL_ST_CAPTURE;
      src_ff    <= SSEL_SRC_DEFAULTS;
      timing_ff <= SSEL_WR_LARGE;
    end
    else
    begin
      state_ff  <= nxt_state;
      src_ff    <= nxt_src;
      timing_ff <= nxt_timing;
    end
  end

  // Pin drive: only the loader phases own the pins
  // released while reset asserted
  wire logic drive_pins = ~por_active &
                          ((state_ff == SSEL_ST_PROBE) |
                           (state_ff == SSEL_ST_LOAD));

  ssel_pin_drv_t drv_ff;
  logic          drive_ff;

  // Registered pin values avoid glitches on the EEPROM clock
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      drv_ff   <= '0;
      drive_ff <= 1'b0;
    end
    else
    begin
      drv_ff   <= drive_pins ? i_load_drv : '0;
      drive_ff <= drive_pins;
    end
  end

  // Enable also cut at once by the reset pin, not a cycle later
  wire logic pin_oe_n = ~(drive_ff & ~por_active);

  assign o_eeprom_select_pin        = drv_ff.select;
  assign o_eeprom_clock_pin         = drv_ff.clock;
  assign o_eeprom_data_out_pin      = drv_ff.data;
  assign o_eeprom_select_pin_oe_n   = pin_oe_n;
  assign o_eeprom_clock_pin_oe_n    = pin_oe_n;
  assign o_eeprom_data_out_pin_oe_n = pin_oe_n;

  // Link edge detection on synchronised levels
  logic clk_prev_ff;
  logic sel_prev_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      clk_prev_ff <= 1'b0;
      sel_prev_ff <= 1'b0;
    end
    else
    begin
      clk_prev_ff <= link_clk_s;
      sel_prev_ff <= link_sel_s;
    end
  end

  wire logic in_run   = (state_ff == SSEL_ST_RUN) & ~por_active;
  wire logic clk_rise = link_clk_s & ~clk_prev_ff & in_run;
  wire logic sel_fall = ~link_sel_s & sel_prev_ff & in_run;
  wire logic idle_rise = clk_rise & ~link_sel_s;

  // count clocks while select idles
  // Armed by the end of a frame; the first idle clock commits the
  // write, any further one before the next frame is an error
  logic [1:0] idle_cnt_ff;
  logic [1:0] nxt_idle_cnt;
  logic       armed_ff;

  assign nxt_idle_cnt = sel_fall ? 2'h0
                      : (idle_rise & armed_ff & (idle_cnt_ff != 2'h3))
                        ? idle_cnt_ff + 2'h1
                        : idle_cnt_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst | ~in_run)
    begin
      idle_cnt_ff <= 2'h0;
      armed_ff    <= 1'b0;
    end
    else
    begin
      idle_cnt_ff <= nxt_idle_cnt;
      armed_ff    <= sel_fall | (armed_ff & ~link_sel_s);
    end
  end

  // Commit and error pulses, plus sampled link data
  logic commit_ff;
  logic error_ff;
  logic rise_ff;
  logic data_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      commit_ff <= 1'b0;
      error_ff  <= 1'b0;
      rise_ff   <= 1'b0;
      data_ff   <= 1'b0;
    end
    else
    begin
      commit_ff <= idle_rise & armed_ff &
                   (idle_cnt_ff == `SSEL_IDLE_CLK_CNT - 2'h1);
      error_ff  <= idle_rise & armed_ff &
                   (idle_cnt_ff >= `SSEL_IDLE_CLK_CNT);
      rise_ff   <= clk_rise & link_sel_s;
      data_ff   <= clk_rise & link_sel_s ? link_dat_s : data_ff;
    end
  end

  // Outputs
  assign o_straps         = straps_ff;
  assign o_master_mode    = is_master;
  assign o_cfg_src        = src_ff;
  assign o_wr_timing      = timing_ff;
  assign o_probe_req      = (state_ff == SSEL_ST_PROBE) & ~por_active;
  assign o_load_req       = (state_ff == SSEL_ST_LOAD) & ~por_active;
  assign o_cfg_ready      = in_run;
  assign o_link_rise      = rise_ff;
  assign o_link_data      = data_ff;
  assign o_wr_commit      = commit_ff;
  assign o_idle_clk_error = error_ff;

endmodule

`default_nettype wire

// ### ssel_strap_latch_assertions.sv
// Port checker for the strap latch block
`include "ssel_params.svh"
`default_nettype none

module ssel_strap_latch_assertions
  import ssel_pkg::*;
(
  // Clock, reset and pins
  input wire logic            i_clk,
  input wire logic            i_rst,
  input wire logic            i_power_on_reset_low,
  // Probe answers
  input wire logic            i_probe_done,
  input wire logic            i_probe_found,
  input wire logic            i_probe_large,
  input wire logic            i_probe_sig_ok,
  // Watched outputs
  input wire logic            o_eeprom_select_pin_oe_n,
  input wire logic            o_eeprom_clock_pin_oe_n,
  input wire logic            o_eeprom_data_out_pin_oe_n,
  input wire ssel_straps_t    o_straps,
  input wire logic            o_master_mode,
  input wire ssel_src_t       o_cfg_src,
  input wire ssel_wr_timing_t o_wr_timing,
  input wire logic            o_probe_req,
  input wire logic            o_load_req,
  input wire logic            o_cfg_ready,
  // Loader drive and the pin values it should reach
  input wire ssel_pin_drv_t   i_load_drv,
  input wire logic            o_eeprom_select_pin,
  input wire logic            o_eeprom_clock_pin,
  input wire logic            o_eeprom_data_out_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [2:0] por_ff;
  logic       por_ok;
  logic       act;
  logic [2:0] oe_n;
  logic       pd;
  // Pin history, so a fresh reset or pin drop never trips a check
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      por_ff <= 3'h0;
    else
      por_ff <= {por_ff[1:0], i_power_on_reset_low};
  end
  assign por_ok = (&por_ff) & i_power_on_reset_low;
  assign act = o_probe_req | o_load_req;
  assign pd = o_probe_req & i_probe_done & por_ok & i_probe_found;
  assign oe_n = {o_eeprom_select_pin_oe_n, o_eeprom_clock_pin_oe_n,
                 o_eeprom_data_out_pin_oe_n};

  property p_hold;
    o_cfg_ready && por_ok |=> $stable(o_straps);
  endproperty
  a_hold: assert property (p_hold)
    else $error("straps moved after release");
  property p_master;
    o_master_mode == (o_straps.chip_addr == `SSEL_ADDR_MASTER);
  endproperty
  a_master: assert property (p_master)
    else $error("master flag wrong");
  property p_por_oe;
    !i_power_on_reset_low [*3] |-> &oe_n;
  endproperty
  a_por_oe: assert property (p_por_oe)
    else $error("pins driven in reset");
  property p_drive;
    act && $past(act) && por_ok |-> oe_n == 3'h0;
  endproperty
  a_drive: assert property (p_drive)
    else $error("pins not driven in load");
  property p_run_rel;
    o_cfg_ready && $past(o_cfg_ready) |-> &oe_n;
  endproperty
  a_run_rel: assert property (p_run_rel)
    else $error("pins driven in run");
  property p_small;
    pd && !i_probe_large && i_probe_sig_ok |=> o_load_req &&
      o_cfg_src == SSEL_SRC_SMALL && o_wr_timing == SSEL_WR_SMALL;
  endproperty
  a_small: assert property (p_small)
    else $error("small load wrong");
  property p_large;
    pd && i_probe_large |=> o_load_req &&
      o_cfg_src == SSEL_SRC_FIRST_CONFIG_BANK && o_wr_timing == SSEL_WR_LARGE;
  endproperty
  a_large: assert property (p_large)
    else $error("large load wrong");
  property p_miss;
    o_probe_req && i_probe_done && por_ok && !i_probe_found |=>
      o_cfg_ready && o_cfg_src == SSEL_SRC_DEFAULTS &&
      o_wr_timing == SSEL_WR_LARGE;
  endproperty
  a_miss: assert property (p_miss)
    else $error("defaults not taken");
  // loader values reach the pins one cycle later
  property p_pin_val;
    act |=> {o_eeprom_select_pin, o_eeprom_clock_pin,
             o_eeprom_data_out_pin} == $past(i_load_drv);
  endproperty
  a_pin_val: assert property (p_pin_val)
    else $error("pin values not from loader");
endmodule

bind ssel_strap_latch ssel_strap_latch_assertions u_chk (
  .i_clk(i_clk), .i_rst(i_rst),
  .i_power_on_reset_low(i_power_on_reset_low),
  .i_probe_done(i_probe_done), .i_probe_found(i_probe_found),
  .i_probe_large(i_probe_large), .i_probe_sig_ok(i_probe_sig_ok),
  .o_eeprom_select_pin_oe_n(o_eeprom_select_pin_oe_n),
  .o_eeprom_clock_pin_oe_n(o_eeprom_clock_pin_oe_n),
  .o_eeprom_data_out_pin_oe_n(o_eeprom_data_out_pin_oe_n),
  .o_straps(o_straps), .o_master_mode(o_master_mode),
  .o_cfg_src(o_cfg_src), .o_wr_timing(o_wr_timing),
  .o_probe_req(o_probe_req), .o_load_req(o_load_req),
  .o_cfg_ready(o_cfg_ready), .i_load_drv(i_load_drv),
  .o_eeprom_select_pin(o_eeprom_select_pin),
  .o_eeprom_clock_pin(o_eeprom_clock_pin),
  .o_eeprom_data_out_pin(o_eeprom_data_out_pin)
);

`default_nettype wire

// ### ssel_strap_latch_tb.sv
// Self-checking bench for the strap latch block
`default_nettype none

module ssel_strap_latch_tb
  import ssel_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic por_n = 1'b0;
  logic [3:0] st = 4'h8;
  logic [5:0] pcfg = 6'h0;
  logic sel_x = 1'b0;
  logic ck_x = 1'b0;
  logic dat_x = 1'b0;
  logic ldat;
  logic [7:0] n_rise = 8'h0;
  logic [7:0] n_com = 8'h0;
  logic [7:0] n_err = 8'h0;
  logic [31:0] seed = 32'h21;
  logic [31:0] r;
  logic pdn, ldn, rise, com, ierr;
  logic so, co, dox, soe, coe, doe, master, prq, lrq, rdy;
  logic [2:0] pres;
  ssel_pin_drv_t drv;
  ssel_straps_t straps;
  ssel_src_t src;
  ssel_wr_timing_t tim;
  int bad_count = 0;
  int samples_checked = 0;
  logic [9:0] corner [7] = '{10'h205, 10'h13e, 10'h31c, 10'h010,
                             10'h245, 10'h285, 10'h3c5};
  // Released pins follow the far side, which idles them low
  wire sel_w = soe ? sel_x : so;
  wire ck_w = coe ? ck_x : co;
  wire dat_w = doe ? dat_x : dox;

  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  // Link pulse counters
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      n_rise <= 8'h0;
      n_com <= 8'h0;
      n_err <= 8'h0;
    end
    else
    begin
      n_rise <= n_rise + {7'h0, rise};
      n_com <= n_com + {7'h0, com};
      n_err <= n_err + {7'h0, ierr};
    end
  end

  ssel_eeprom_model u_eep (.i_clk(i_clk), .i_rst(i_rst),
    .i_cfg(pcfg), .i_probe_req(prq), .i_load_req(lrq),
    .o_probe_done(pdn), .o_probe(pres), .o_drv(drv),
    .o_load_done(ldn));

  ssel_strap_latch dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_power_on_reset_low(por_n), .i_flow_ctrl_strap(st[3]),
    .i_port4_fiber_select(st[2]), .i_chip_addr_strap_lo(st[0]),
    .i_chip_addr_strap_hi(st[1]), .i_probe_done(pdn),
    .i_probe_found(pres[2]), .i_probe_large(pres[1]),
    .i_probe_sig_ok(pres[0]), .i_load_drv(drv), .i_load_done(ldn),
    .i_eeprom_select_pin(sel_w), .o_eeprom_select_pin(so),
    .o_eeprom_select_pin_oe_n(soe), .i_eeprom_clock_pin(ck_w),
    .o_eeprom_clock_pin(co), .o_eeprom_clock_pin_oe_n(coe),
    .i_eeprom_data_out_pin(dat_w), .o_eeprom_data_out_pin(dox),
    .o_eeprom_data_out_pin_oe_n(doe), .o_straps(straps),
    .o_master_mode(master), .o_cfg_src(src), .o_wr_timing(tim),
    .o_probe_req(prq), .o_load_req(lrq), .o_cfg_ready(rdy),
    .o_link_rise(rise), .o_link_data(ldat), .o_wr_commit(com),
    .o_idle_clk_error(ierr));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {master, source, timing}
  function automatic logic [3:0] exp_cfg(logic [3:0] s, logic [5:0] p);
    if (s[1:0] != 2'h0)
      return {1'b0, SSEL_SRC_DEFAULTS, SSEL_WR_LARGE};
    if (p[2] && p[1])
      return {1'b1, SSEL_SRC_FIRST_CONFIG_BANK, SSEL_WR_LARGE};
    if (p[2] && p[0])
      return {1'b1, SSEL_SRC_SMALL, SSEL_WR_SMALL};
    return {1'b1, SSEL_SRC_DEFAULTS, SSEL_WR_LARGE};
  endfunction

  task automatic report(logic [7:0] g, logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_straps(ssel_straps_t g, logic [3:0] e);
    report({4'h0, g}, {4'h0, e});
  endtask
  task automatic chk_cfg(logic [3:0] g, logic [3:0] e);
    report({4'h0, g}, {4'h0, e});
  endtask
  task automatic chk_cnt(logic [7:0] g, logic [7:0] e);
    report(g, e);
  endtask
  task automatic chk_data(logic g, logic e);
    report({7'h0, g}, {7'h0, e});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Power-on cycle, then straps move once latched
  task automatic run_cfg(logic [3:0] s, logic [5:0] p);
    int i;
    @(posedge i_clk);
    por_n <= 1'b0;
    st <= s;
    pcfg <= p;
    repeat (6) @(posedge i_clk);
    por_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    st <= ~s;
    i = 0;
    while (rdy !== 1'b1 && i < 64)
    begin
      @(posedge i_clk);
      i++;
    end
    if (i == 64)
    begin
      bad_count++;
      give_verdict();
    end
    chk_straps(straps, s);
    chk_cfg({master, src, tim}, exp_cfg(s, p));
  endtask

  task automatic pulse(logic d);
    dat_x = d;
    #62.5 ck_x = 1'b1;
    #62.5 ck_x = 1'b0;
  endtask

  // Link clock stands still outside these pulses
  task automatic link_wr(logic [7:0] idle);
    logic [31:0] w;
    logic [7:0]  b_rise;
    logic [7:0]  b_com;
    logic [7:0]  b_err;
    w = rnd();
    // Loader pin levels drain through the synchroniser first
    repeat (8) @(posedge i_clk);
    #3;
    b_rise = n_rise;
    b_com = n_com;
    b_err = n_err;
    sel_x = 1'b1;
    for (int j = 3; j >= 0; j--)
      pulse(w[j]);
    sel_x = 1'b0;
    dat_x = 1'b0;
    #100;
    repeat (idle) pulse(1'b0);
    repeat (8) @(posedge i_clk);
    chk_cnt(n_rise - b_rise, 8'h4);
    chk_cnt(n_com - b_com, 8'h1);
    chk_cnt(n_err - b_err, idle - 8'h1);
    chk_data(ldat, w[0]);
  endtask

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int k = 0; k < 15; k++)
    begin
      r = (k < 7) ? {22'h0, corner[k]} : rnd();
      run_cfg(r[9:6], r[5:0]);
      link_wr(8'(k % 3 + 1));
      chk_straps(straps, r[9:6]);
      $display("test %0d done", k);
    end
    give_verdict();
  end
endmodule

`default_nettype wire

// ### ssel_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`default_nettype none

module ssel_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_rst_val,
  output var  logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  // Reset value shown until the chain has filled
  logic [1:0] fill_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      fill_ff <= 2'h0;
    else if (fill_ff != 2'h2)
      fill_ff <= fill_ff + 2'h1;
  end

  assign o_sync = (fill_ff == 2'h2) ? sync_ff : i_rst_val;

endmodule

`default_nettype wire
